// >>> hw/rpc_pkg.sv
// Purpose: Shared constants and types for the root pointer and context command registers
// Assumes: AHB-Lite slave, 32-bit data, one word per offset
// Notes: 64-bit registers occupy two words each (low word at the printed offset)
package rpc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] RPC_OFS_ROOT_LO = 8'h20;
    localparam logic [7:0] RPC_OFS_ROOT_HI = 8'h24;
    localparam logic [7:0] RPC_OFS_CTX_LO = 8'h28;
    localparam logic [7:0] RPC_OFS_CTX_HI = 8'h2C;
    localparam logic [7:0] RPC_OFS_GCMD = 8'h30;
    localparam logic [7:0] RPC_OFS_GSTS = 8'h34;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int RPC_HAW = 48;
    localparam int RPC_BASE_LSB = 12;
    localparam int RPC_MODE_LSB = 10;
    localparam int RPC_GCMD_SET_ROOT_BIT = 30;
    localparam int RPC_GCMD_ENABLE_BIT = 31;
    localparam int RPC_GSTS_ENABLED_BIT = 31;
    localparam int RPC_GSTS_ROOT_BIT = 30;
    localparam int RPC_CTX_INV_BIT = 31;
    localparam int RPC_CTX_MODE_BIT = 0;
    localparam logic [1:0] RPC_MODE_RST = 2'h0;
    localparam logic [RPC_HAW-13:0] RPC_BASE_RST = '0;
    localparam logic [1:0] RPC_MODE_LEGACY = 2'h0;
    localparam logic [1:0] RPC_MODE_SCALABLE = 2'h1;
    localparam logic [1:0] RPC_MODE_RESERVED = 2'h2;
    localparam logic [1:0] RPC_MODE_ABORT = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RPC_CLK_NS = 50;
    localparam int RPC_APPLY_NS = 100;
    localparam int RPC_APPLY_CYC = (RPC_APPLY_NS + RPC_CLK_NS - 1) / RPC_CLK_NS;
    localparam int RPC_INVAL_NS = 400;
    localparam int RPC_INVAL_CYC = (RPC_INVAL_NS + RPC_CLK_NS - 1) / RPC_CLK_NS;

    typedef enum logic [1:0] {RPC_IDLE, RPC_BUSY, RPC_DONE} rpc_seq_e;

    typedef struct packed {
        logic [RPC_HAW-13:0] base;
        logic [1:0] mode;
    } rpc_root_s;

    typedef struct packed {
        logic legacy;
        logic scalable;
        logic abort_dma;
        logic reserved;
    } rpc_mode_s;
endpackage : rpc_pkg

// >>> hw/rpc_mode_dec.sv
// Purpose: Decodes the active translation mode
// Assumes: Input is the active (applied) mode
// Notes: Registered outputs
`timescale 1ns/1ps
module rpc_mode_dec
    import rpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] mode,
    output rpc_mode_s dec
);
    rpc_mode_s st_q;
    rpc_mode_s st_d;

    always_comb begin
        st_d = '0;
        case (mode)
            RPC_MODE_LEGACY: st_d.legacy = 1'b1;
            RPC_MODE_SCALABLE: st_d.scalable = 1'b1;
            RPC_MODE_ABORT: st_d.abort_dma = 1'b1;
            default: st_d.reserved = 1'b1;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '{legacy: 1'b1, default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign dec = st_q;

    AST_RESERVED_ONLY_FOR_10: assert property (@(posedge hclk) disable iff (!hresetn)
        dec.reserved |-> $past(mode) == RPC_MODE_RESERVED)
        else $error("reserved decode without encoding 10");
    AST_ONE_HOT: assert property (@(posedge hclk) disable iff (!hresetn)
        $onehot(dec))
        else $error("mode decode not one-hot");
endmodule : rpc_mode_dec

// >>> hw/rpc_timer.sv
// Purpose: Busy sequencer for apply and invalidate operations
// Assumes: start is a one-cycle pulse while idle
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
module rpc_timer
    import rpc_pkg::*;
#(
    parameter int CYC = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    output logic busy,
    output logic done
);
    typedef struct packed {
        rpc_seq_e seq;
        logic [7:0] cnt;
    } rpc_tmr_s;
    rpc_tmr_s st_q;
    rpc_tmr_s st_d;

    always_comb begin
        st_d = st_q;
        case (st_q.seq)
            RPC_IDLE: begin
                if (start) begin
                    st_d.seq = RPC_BUSY;
                    st_d.cnt = 8'(CYC - 1);
                end
            end
            RPC_BUSY: begin
                if (st_q.cnt == 8'h00) begin
                    st_d.seq = RPC_DONE;
                end else begin
                    st_d.cnt = st_q.cnt - 8'h01;
                end
            end
            default: st_d.seq = RPC_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '{seq: RPC_IDLE, cnt: 8'h00};
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = (st_q.seq != RPC_IDLE);
    assign done = (st_q.seq == RPC_DONE);
endmodule : rpc_timer

// >>> hw/rpc_regs.sv
// Purpose: Root pointer and context-cache command registers on AHB-Lite
// Assumes: Single word transfers, zero wait state, OKAY always
// Notes: Staged root pointer is applied on the set-root-pointer command
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module rpc_regs
    import rpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [51:0] root_table_base,
    output logic [1:0] active_mode,
    output logic mode_scalable,
    output logic mode_abort,
    output logic ctx_inval_busy
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        rpc_root_s staged;
        rpc_root_s active;
        logic enabled;
        logic root_ok;
        logic inv_pend;
        logic ctx_mode;
        logic [31:0] rdata;
        logic [51:0] base_out;
        logic [1:0] mode_out;
    } rpc_st_s;
    rpc_st_s st_q;
    rpc_st_s st_d;

    logic apply_start;
    logic apply_busy;
    logic apply_done;
    logic inv_start;
    logic inv_done;
    rpc_mode_s dec;

    logic addr_ok;
    logic [7:0] rd_ofs;
    logic [31:0] rd_val;

    rpc_timer #(.CYC(RPC_APPLY_CYC)) u_apply (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(apply_start),
        .busy(apply_busy),
        .done(apply_done)
    );

    // No cache sits behind this block; a fixed delay models the invalidation
    rpc_timer #(.CYC(RPC_INVAL_CYC)) u_inval (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(inv_start),
        .busy(),
        .done(inv_done)
    );

    rpc_mode_dec u_dec (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(st_q.active.mode),
        .dec(dec)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Reads are captured in the address phase, so a read straight after a
    // write to the same word returns the value from before that write
    assign addr_ok = hsel && hready && htrans[1];
    assign rd_ofs = haddr[7:0];

    always_comb begin
        rd_val = 32'h0000_0000;
        case (rd_ofs)
            // Reserved bits 9:0 read zero
            RPC_OFS_ROOT_LO: begin
                rd_val = {st_q.staged.base[19:0], st_q.staged.mode, 10'h000};
            end
            // Bits above the host address width read zero
            RPC_OFS_ROOT_HI: begin
                rd_val = {{(64 - RPC_HAW){1'b0}}, st_q.staged.base[RPC_HAW-13:20]};
            end
            RPC_OFS_CTX_LO: rd_val = 32'h0000_0000;
            RPC_OFS_CTX_HI: rd_val = {st_q.inv_pend, 31'h0000_0000};
            RPC_OFS_GCMD: rd_val = 32'h0000_0000;
            RPC_OFS_GSTS: rd_val = {st_q.enabled, st_q.root_ok, 30'h0000_0000};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        apply_start = 1'b0;
        inv_start = 1'b0;
        st_d.wr_pend = addr_ok && hwrite;
        if (addr_ok) begin
            st_d.wr_addr = rd_ofs;
        end
        if (addr_ok && !hwrite) begin
            st_d.rdata = rd_val;
        end
        // Write data phase
        if (st_q.wr_pend) begin
            case (st_q.wr_addr)
                RPC_OFS_ROOT_LO: begin
                    st_d.staged.base[19:0] = hwdata[31:12];
                    st_d.staged.mode = hwdata[11:10];
                end
                RPC_OFS_ROOT_HI: begin
                    st_d.staged.base[RPC_HAW-13:20] = hwdata[RPC_HAW-33:0];
                end
                // Stored but never read back (reads zero); it steers nothing here
                RPC_OFS_CTX_LO: st_d.ctx_mode = hwdata[RPC_CTX_MODE_BIT];
                // Top byte lives in this word; a set bit while pending is ignored
                RPC_OFS_CTX_HI: begin
                    if (hwdata[RPC_CTX_INV_BIT] && !st_q.inv_pend) begin
                        st_d.inv_pend = 1'b1;
                        inv_start = 1'b1;
                    end
                end
                RPC_OFS_GCMD: begin
                    st_d.enabled = hwdata[RPC_GCMD_ENABLE_BIT];
                    // A second set-root-pointer during a copy is dropped, not queued
                    if (hwdata[RPC_GCMD_SET_ROOT_BIT] && !apply_busy) begin
                        st_d.root_ok = 1'b0;
                        apply_start = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (apply_done) begin
            st_d.active = st_q.staged;
            st_d.root_ok = 1'b1;
        end
        // A clear cannot meet a set: new requests are refused while pending
        if (inv_done) begin
            st_d.inv_pend = 1'b0;
        end
        st_d.base_out = {{(64 - RPC_HAW){1'b0}}, st_q.active.base};
        st_d.mode_out = st_q.active.mode;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            st_q.staged <= '{base: RPC_BASE_RST, mode: RPC_MODE_RST};
            st_q.active <= '{base: RPC_BASE_RST, mode: RPC_MODE_RST};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = st_q.rdata;
    // Zero wait state: the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign root_table_base = st_q.base_out;
    assign active_mode = st_q.mode_out;
    assign mode_scalable = dec.scalable;
    assign mode_abort = dec.abort_dma;
    assign ctx_inval_busy = st_q.inv_pend;

    // ------------------------------------------------------------
    // Checks: bus reads
    // ------------------------------------------------------------
    // Read data is compared with the state seen in the address phase
    AST_LOW_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && rd_ofs == RPC_OFS_ROOT_LO |=> hrdata[9:0] == 10'h000)
        else $error("reserved root bits not zero");
    AST_ROOT_HI_RD: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && rd_ofs == RPC_OFS_ROOT_HI |=> hrdata[31:RPC_HAW-32] == '0)
        else $error("root bits above host width read non-zero");
    AST_ENABLED_RD: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && rd_ofs == RPC_OFS_GSTS |=>
        hrdata[RPC_GSTS_ENABLED_BIT] == $past(st_q.enabled))
        else $error("enabled status read wrong");
    AST_GSTS_ROOT_RD: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && rd_ofs == RPC_OFS_GSTS |=>
        hrdata[RPC_GSTS_ROOT_BIT] == $past(st_q.root_ok))
        else $error("root status read wrong");

    // ------------------------------------------------------------
    // Checks: root pointer
    // ------------------------------------------------------------
    // Apply lasts the timer count plus one done cycle
    AST_STAGED_NOT_ACTIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        !apply_done |=> st_q.active == $past(st_q.active))
        else $error("active pointer changed without apply");
    AST_APPLY_COPIES: assert property (@(posedge hclk) disable iff (!hresetn)
        apply_done |=> st_q.active == $past(st_q.staged))
        else $error("apply did not copy staged pointer");
    AST_BASE_STAGED: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.wr_pend && st_q.wr_addr == RPC_OFS_ROOT_LO |=>
        st_q.staged.base[19:0] == $past(hwdata[31:RPC_BASE_LSB]))
        else $error("low root base not staged");
    AST_MODE_STAGED: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.wr_pend && st_q.wr_addr == RPC_OFS_ROOT_LO |=>
        st_q.staged.mode == $past(hwdata[RPC_MODE_LSB+1:RPC_MODE_LSB]))
        else $error("mode not staged");
    AST_HI_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.wr_pend && st_q.wr_addr == RPC_OFS_ROOT_HI |=>
        st_q.staged.base[RPC_HAW-13:20] == $past(hwdata[RPC_HAW-33:0]))
        else $error("high root base not staged");
    AST_HI_KEEPS_MODE: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.wr_pend && st_q.wr_addr == RPC_OFS_ROOT_HI |=> $stable(st_q.staged.mode))
        else $error("high word write changed mode");
    AST_GCMD_NO_STAGE: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.wr_pend && st_q.wr_addr == RPC_OFS_GCMD |=> $stable(st_q.staged))
        else $error("command write changed staged pointer");
    AST_MODE_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 active_mode == $past(st_q.active.mode))
        else $error("active mode port wrong");
    AST_BASE_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 root_table_base[RPC_HAW-13:0] == $past(st_q.active.base))
        else $error("root base port wrong");
    AST_BASE_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 root_table_base[51:RPC_HAW-12] == '0)
        else $error("bits above host width driven");
    AST_SCALABLE_DEC: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 mode_scalable == ($past(st_q.active.mode) == RPC_MODE_SCALABLE))
        else $error("scalable decode wrong");
    AST_ABORT_DEC: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 mode_abort == ($past(st_q.active.mode) == RPC_MODE_ABORT))
        else $error("abort decode wrong");
    AST_ROOT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        apply_start |=> !st_q.root_ok ##[1:8] st_q.root_ok)
        else $error("root status sequence wrong");
    AST_ROOT_OK_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_q.root_ok) |-> $past(apply_done))
        else $error("root status set without apply");
    AST_ROOT_OK_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(st_q.root_ok) |-> $past(apply_start))
        else $error("root status cleared without command");
    AST_ENABLED_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !(st_q.wr_pend && st_q.wr_addr == RPC_OFS_GCMD) |=> $stable(st_q.enabled))
        else $error("enabled status changed without command");
    AST_RESET_LEGACY: assert property (@(posedge hclk)
        !hresetn |=> active_mode == RPC_MODE_LEGACY || !hresetn)
        else $error("reset mode not legacy");
    AST_RESET_BASE: assert property (@(posedge hclk)
        !hresetn |=> root_table_base == '0 || !hresetn)
        else $error("reset base not zero");

    // ------------------------------------------------------------
    // Checks: invalidation
    // ------------------------------------------------------------
    // Nine busy cycles: the timer spends one extra cycle in its done state
    AST_INV_START: assert property (@(posedge hclk) disable iff (!hresetn)
        inv_start |=> st_q.inv_pend)
        else $error("invalidate bit not set");
    AST_INV_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_q.inv_pend) |-> $past(inv_start))
        else $error("invalidate bit set without request");
    AST_INV_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
        inv_start |=> st_q.inv_pend [*8] ##1 st_q.inv_pend ##1 !st_q.inv_pend)
        else $error("invalidate did not finish on time");
    AST_INV_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(st_q.inv_pend) |-> $past(inv_done))
        else $error("invalidate bit cleared early");
    AST_INV_RD: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && rd_ofs == RPC_OFS_CTX_HI |=>
        hrdata[RPC_CTX_INV_BIT] == $past(st_q.inv_pend))
        else $error("invalidate bit read wrong");

    COV_APPLY: cover property (@(posedge hclk) disable iff (!hresetn) apply_done);
    COV_INVAL: cover property (@(posedge hclk) disable iff (!hresetn) inv_done);
    COV_ABORT: cover property (@(posedge hclk) disable iff (!hresetn) mode_abort);
    COV_SCALABLE: cover property (@(posedge hclk) disable iff (!hresetn) mode_scalable);
    COV_RESERVED: cover property (@(posedge hclk) disable iff (!hresetn) dec.reserved);
endmodule : rpc_regs

// >>> test/rpc_regs_bench.sv
// Purpose: Self-checking bench for the root pointer and context command registers
// Assumes: Zero wait state slave, hready looped back from hreadyout
// Notes: Random base values come from a fixed seed; every mode encoding is swept
`timescale 1ns/1ps
module rpc_regs_bench;
    import rpc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [51:0] root_table_base;
    logic [1:0] active_mode;
    logic mode_scalable;
    logic mode_abort;
    logic ctx_inval_busy;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [1:0] m;
    logic [1:0] pm;
    logic [51:0] pb;
    logic seen0;
    logic [7:0] rst_ofs [6] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h34, 8'h40};

    rpc_regs u_rpc_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .root_table_base(root_table_base), .active_mode(active_mode),
        .mode_scalable(mode_scalable), .mode_abort(mode_abort),
        .ctx_inval_busy(ctx_inval_busy));

    // ------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------
    initial begin
        forever #25 hclk = ~hclk;
    end

    // A hung poll loop must still reach the verdict
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_port(input logic [63:0] got, input logic [63:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t port got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_port

    function automatic logic [51:0] exp_base(input logic [31:0] h, input logic [31:0] l);
        return {16'h0, h[15:0], l[31:12]};
    endfunction : exp_base

    // ------------------------------------------------------------
    // AHB-Lite single transfers
    // ------------------------------------------------------------
    task automatic bus_cycle(input logic wr, input logic [31:0] a, input logic [31:0] d,
                             output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        // Let this edge's register updates land before ports are looked at
        #1;
    endtask : bus_cycle

    task automatic wr32(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus_cycle(1'b1, a, d, unused);
    endtask : wr32

    task automatic rd32(input logic [31:0] a, output logic [31:0] q);
        bus_cycle(1'b0, a, 32'h0, q);
    endtask : rd32

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(35));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd32({24'h0, rst_ofs[i]}, rd);
            chk_reg(rd, 32'h0);
        end
        chk_port(root_table_base, 64'h0);
        chk_port(active_mode, 64'h0);
        chk_port({hreadyout, hresp}, 64'h2);
        wr32(32'h40, $urandom);
        rd32(32'h40, rd);
        chk_reg(rd, 32'h0);
        pm = 2'h0;
        pb = 52'h0;
        // Sweep ends on legacy, the reset mode; the context command does not depend on the mode
        for (int k = 0; k < 4; k++) begin
            m = 2'(k + 1);
            lo = (k == 2) ? 32'hFFFFFFFF : $urandom;
            hi = (k == 2) ? 32'hFFFFFFFF : $urandom;
            lo[11:10] = m;
            wr32(32'h20, lo);
            wr32(32'h24, hi);
            rd32(32'h20, rd);
            chk_reg(rd, lo & 32'hFFFFFC00);
            rd32(32'h24, rd);
            chk_reg(rd, hi & 32'h0000FFFF);
            chk_port(active_mode, pm);
            chk_port(root_table_base, pb);
            wr32(32'h30, 32'h40000000);
            seen0 = 1'b0;
            for (int i = 0; i < 20; i++) begin
                rd32(32'h34, rd);
                if (rd[30] === 1'b1) break;
                seen0 = 1'b1;
            end
            chk_port(seen0, 64'h1);
            chk_reg(rd & 32'h40000000, 32'h40000000);
            pm = m;
            pb = exp_base(hi, lo);
            chk_port(active_mode, pm);
            chk_port(root_table_base, pb);
            chk_port({mode_scalable, mode_abort}, {m == 2'h1, m == 2'h3});
        end
        wr32(32'h2C, 32'h7F000000);
        chk_port(ctx_inval_busy, 64'h0);
        wr32(32'h28, $urandom);
        chk_port(ctx_inval_busy, 64'h0);
        wr32(32'h2C, 32'h80000000);
        chk_port(ctx_inval_busy, 64'h1);
        rd32(32'h2C, rd);
        chk_reg(rd & 32'h80000000, 32'h80000000);
        for (int i = 0; i < 20 && rd[31] !== 1'b0; i++) begin
            rd32(32'h2C, rd);
        end
        chk_reg(rd & 32'h80000000, 32'h0);
        chk_port(ctx_inval_busy, 64'h0);
        wr32(32'h30, 32'h80000000);
        for (int i = 0; i < 10; i++) begin
            rd32(32'h34, rd);
            if (rd[31] === 1'b1) break;
        end
        chk_reg(rd & 32'h80000000, 32'h80000000);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        chk_port({root_table_base, active_mode}, 64'h0);
        chk_port({mode_scalable, mode_abort, ctx_inval_busy}, 64'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        rd32(32'h20, rd);
        chk_reg(rd, 32'h0);
        rd32(32'h34, rd);
        chk_reg(rd, 32'h0);
        end_sim();
    end
endmodule : rpc_regs_bench
